//--- hw/paz_area_zero.sv
`timescale 1ns/1ps
`include "paz_params.svh"
// Functional notes
// - Y end at bits 29-24, 8-line units
// - X end at bits 21-16, 8-pixel units
// - Y start at bits 13-8, 8-line units
// - X start at bits 5-0, 8-pixel units
// - Bounds act only for partial-refresh panel
// - Bounds act only while partial enable set
// - Stripe uses Y only; block uses both
module paz_area_zero
  import paz_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Panel timing side
  input wire logic [2:0] panel_type_in,
  input wire logic [8:0] line_in,
  input wire logic [8:0] pixel_in,
  // Area status
  output logic area_active_out,
  output logic partial_en_out,
  output logic block_type_out,
  output logic [31:0] bounds_out
);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  paz_bus_st_t st_q, st_d;
  logic [31:0] bounds_q, ctrl_q, rdata_q;
  wire req_w = avs_read_in | avs_write_in;
  wire take_w = req_w && (st_q == PAZ_IDLE);
  wire ack_w = req_w && (st_q == PAZ_DONE);
  wire hit_bounds_w = avs_address_in == `PAZ_OFF_BOUNDS;
  wire hit_ctrl_w = avs_address_in == `PAZ_OFF_CTRL;
  wire [31:0] be_mask_w = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                           {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire [31:0] bounds_wr_w = ((bounds_q & ~be_mask_w) | (avs_writedata_in & be_mask_w))
                            & `PAZ_BOUNDS_MASK;
  wire [31:0] ctrl_wr_w = ((ctrl_q & ~be_mask_w) | (avs_writedata_in & be_mask_w))
                          & `PAZ_CTRL_MASK;
  wire [31:0] rsel_w = hit_bounds_w ? bounds_q : (hit_ctrl_w ? ctrl_q : 32'h00000000);
  // Writes land on the acknowledge edge, where the master sees waitrequest low
  wire wr_bounds_w = ack_w && avs_write_in && hit_bounds_w;
  wire wr_ctrl_w = ack_w && avs_write_in && hit_ctrl_w;

  always_comb begin
    unique case (st_q)
      PAZ_IDLE: st_d = take_w ? PAZ_DONE : PAZ_IDLE;
      PAZ_DONE: st_d = PAZ_IDLE;
      default: st_d = PAZ_IDLE;
    endcase
  end

  // Answer one cycle after the request is seen
  assign avs_waitrequest_out = req_w && (st_q != PAZ_DONE);
  assign avs_readdata_out = rdata_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= PAZ_IDLE;
      rdata_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      if (take_w && avs_read_in) begin
        rdata_q <= rsel_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bounds_q <= `PAZ_BOUNDS_RST;
      ctrl_q <= `PAZ_CTRL_RST;
    end else begin
      if (wr_bounds_w) begin
        bounds_q <= bounds_wr_w;
      end
      if (wr_ctrl_w) begin
        ctrl_q <= ctrl_wr_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Area decision
  // ----------------------------------------------------------------
  wire [5:0] y_end_w = bounds_q[`PAZ_YEND_HI:`PAZ_YEND_LO];
  wire [5:0] x_end_w = bounds_q[`PAZ_XEND_HI:`PAZ_XEND_LO];
  wire [5:0] y_sta_w = bounds_q[`PAZ_YSTA_HI:`PAZ_YSTA_LO];
  wire [5:0] x_sta_w = bounds_q[`PAZ_XSTA_HI:`PAZ_XSTA_LO];
  wire en_w = ctrl_q[`PAZ_CTRL_EN_BIT];
  wire blk_w = ctrl_q[`PAZ_CTRL_TYPE_BIT];
  wire panel_ok_w = panel_type_in == `PAZ_PANEL_PARTIAL;
  logic in_y_w, in_x_w;

  paz_range_cmp u_cmp_y (
    .pos_in(line_in),
    .start_in(y_sta_w),
    .end_in(y_end_w),
    .inside_out(in_y_w)
  );

  paz_range_cmp u_cmp_x (
    .pos_in(pixel_in),
    .start_in(x_sta_w),
    .end_in(x_end_w),
    .inside_out(in_x_w)
  );

  wire hit_w = in_y_w && (!blk_w || in_x_w);
  wire active_d = panel_ok_w && en_w && hit_w;
  logic active_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign area_active_out = active_q;
  assign partial_en_out = en_w;
  assign block_type_out = blk_w;
  assign bounds_out = bounds_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  unused_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bounds_q & ~`PAZ_BOUNDS_MASK) == 32'h00000000)
    else $error("reserved bound bits set");

  write_store_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && (avs_byteenable_in == 4'hF)
    |=> bounds_q == ($past(avs_writedata_in) & `PAZ_BOUNDS_MASK))
    else $error("bounds write lost");

  wrong_panel_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !panel_ok_w |=> !area_active_out)
    else $error("area active on other panel");

  enable_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !en_w |=> !area_active_out)
    else $error("area active while disabled");

  stripe_mode_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    panel_ok_w && en_w && !blk_w |=> area_active_out == $past(in_y_w))
    else $error("stripe ignores x wrong");

  block_mode_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    panel_ok_w && en_w && blk_w |=> area_active_out == $past(in_y_w && in_x_w))
    else $error("block area wrong");

  xstart_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_x_w |-> pixel_in >= {x_sta_w, 3'h0})
    else $error("x start unit wrong");

  yend_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_y_w |-> line_in <= {y_end_w, 3'h7})
    else $error("y end unit wrong");

  bus_answer_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w |=> !avs_waitrequest_out)
    else $error("bus answer late");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  state_onehot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $onehot(st_q))
    else $error("bus state not one-hot");

  wait_first_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w |-> avs_waitrequest_out)
    else $error("first cycle not held");

  done_once_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_q == PAZ_DONE |=> st_q == PAZ_IDLE)
    else $error("answer lasts too long");

  idle_stay_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !req_w && (st_q == PAZ_IDLE) |=> st_q == PAZ_IDLE)
    else $error("bus state moved while idle");

  no_wait_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !req_w |-> !avs_waitrequest_out)
    else $error("waitrequest without request");

  read_bounds_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w && avs_read_in && hit_bounds_w |=> avs_readdata_out == $past(bounds_q))
    else $error("bounds read data wrong");

  read_masked_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w && avs_read_in && hit_bounds_w
    |=> (avs_readdata_out & ~`PAZ_BOUNDS_MASK) == 32'h00000000)
    else $error("reserved bits read back");

  read_ctrl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w && avs_read_in && hit_ctrl_w |=> avs_readdata_out == $past(ctrl_q))
    else $error("control read data wrong");

  read_unmapped_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take_w && avs_read_in && !hit_bounds_w && !hit_ctrl_w
    |=> avs_readdata_out == 32'h00000000)
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(take_w && avs_read_in) |=> $stable(avs_readdata_out))
    else $error("read data changed unasked");

  // ----------------------------------------------------------------
  // Register checks
  // ----------------------------------------------------------------
  bounds_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wr_bounds_w |=> $stable(bounds_q))
    else $error("bounds changed without write");

  ctrl_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wr_ctrl_w |=> $stable(ctrl_q))
    else $error("control changed without write");

  ctrl_mask_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ctrl_q & ~`PAZ_CTRL_MASK) == 32'h00000000)
    else $error("control reserved bits set");

  ctrl_store_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl_w && (avs_byteenable_in == 4'hF)
    |=> ctrl_q == ($past(avs_writedata_in) & `PAZ_CTRL_MASK))
    else $error("control write lost");

  unmapped_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ack_w && avs_write_in && !hit_bounds_w && !hit_ctrl_w
    |=> $stable(bounds_q) && $stable(ctrl_q))
    else $error("unmapped write changed state");

  yend_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && !avs_byteenable_in[3] |=> y_end_w == $past(y_end_w))
    else $error("y end lane not kept");

  xend_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && !avs_byteenable_in[2] |=> x_end_w == $past(x_end_w))
    else $error("x end lane not kept");

  ysta_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && !avs_byteenable_in[1] |=> y_sta_w == $past(y_sta_w))
    else $error("y start lane not kept");

  xsta_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && !avs_byteenable_in[0] |=> x_sta_w == $past(x_sta_w))
    else $error("x start lane not kept");

  yend_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && avs_byteenable_in[3]
    |=> y_end_w == $past(avs_writedata_in[`PAZ_YEND_HI:`PAZ_YEND_LO]))
    else $error("y end lane not written");

  xend_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && avs_byteenable_in[2]
    |=> x_end_w == $past(avs_writedata_in[`PAZ_XEND_HI:`PAZ_XEND_LO]))
    else $error("x end lane not written");

  ysta_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && avs_byteenable_in[1]
    |=> y_sta_w == $past(avs_writedata_in[`PAZ_YSTA_HI:`PAZ_YSTA_LO]))
    else $error("y start lane not written");

  xsta_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_bounds_w && avs_byteenable_in[0]
    |=> x_sta_w == $past(avs_writedata_in[`PAZ_XSTA_HI:`PAZ_XSTA_LO]))
    else $error("x start lane not written");

  // ----------------------------------------------------------------
  // Area checks
  // ----------------------------------------------------------------
  yrange_unit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_y_w == ((line_in[8:`PAZ_UNIT_SHIFT] >= y_sta_w)
               && (line_in[8:`PAZ_UNIT_SHIFT] <= y_end_w)))
    else $error("y range in line units wrong");

  xrange_unit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_x_w == ((pixel_in[8:`PAZ_UNIT_SHIFT] >= x_sta_w)
               && (pixel_in[8:`PAZ_UNIT_SHIFT] <= x_end_w)))
    else $error("x range in pixel units wrong");

  xend_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_x_w |-> pixel_in <= {x_end_w, 3'h7})
    else $error("x end unit wrong");

  ystart_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_y_w |-> line_in >= {y_sta_w, 3'h0})
    else $error("y start unit wrong");

  outside_y_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !in_y_w |=> !area_active_out)
    else $error("area active outside lines");

  block_x_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    blk_w && !in_x_w |=> !area_active_out)
    else $error("block area ignores x");

  stripe_x_free_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    panel_ok_w && en_w && !blk_w && in_y_w |=> area_active_out)
    else $error("stripe area missed");

  active_cause_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    area_active_out |-> $past(panel_ok_w && en_w))
    else $error("area active without cause");
endmodule

//--- hw/paz_range_cmp.sv
`timescale 1ns/1ps
`include "paz_params.svh"
// Tests a position against a start/end bound pair given in units of 8
module paz_range_cmp
  import paz_pkg::*;
(
  // Position and bounds
  input wire logic [8:0] pos_in,
  input wire logic [5:0] start_in,
  input wire logic [5:0] end_in,
  // Result
  output logic inside_out
);
  wire [8:0] lo_w = {start_in, 3'h0};
  wire [8:0] hi_w = {end_in, 3'h7};
  assign inside_out = (pos_in >= lo_w) && (pos_in <= hi_w);
endmodule

//--- pkg/paz_params.svh
`ifndef PAZ_PARAMS_SVH
`define PAZ_PARAMS_SVH
// Register byte offsets
`define PAZ_OFF_BOUNDS 8'hE8
`define PAZ_OFF_CTRL 8'hE4
// Field positions in the bounds register
`define PAZ_YEND_HI 29
`define PAZ_YEND_LO 24
`define PAZ_XEND_HI 21
`define PAZ_XEND_LO 16
`define PAZ_YSTA_HI 13
`define PAZ_YSTA_LO 8
`define PAZ_XSTA_HI 5
`define PAZ_XSTA_LO 0
// Writable bits of the bounds register
`define PAZ_BOUNDS_MASK 32'h3F3F3F3F
`define PAZ_BOUNDS_RST 32'h00000000
// Control register bits
`define PAZ_CTRL_EN_BIT 4
`define PAZ_CTRL_TYPE_BIT 3
`define PAZ_CTRL_MASK 32'h00000018
`define PAZ_CTRL_RST 32'h00000000
// Bound units: 8 lines / 8 pixels, shift by 3
`define PAZ_UNIT_SHIFT 3
// Panel interface type code of the partial-refresh panel
`define PAZ_PANEL_PARTIAL 3'h3
`endif

//--- pkg/paz_pkg.sv
package paz_pkg;
  typedef enum logic [1:0] {
    PAZ_IDLE = 2'b01,
    PAZ_DONE = 2'b10
  } paz_bus_st_t;
endpackage

//--- tb/paz_panel_model.sv
`timescale 1ns/1ps
module paz_panel_model (
  // Clock
  input wire logic clk_in,
  // Scan position
  output logic [2:0] panel_type_out,
  output logic [8:0] line_out,
  output logic [8:0] pixel_out
);
  initial begin
    panel_type_out = 3'h0;
    line_out = 9'h000;
    pixel_out = 9'h000;
  end
  // Moves the scan to a new position at the next rising edge
  task automatic place(input logic [2:0] t, input logic [8:0] l, input logic [8:0] p);
    @(posedge clk_in);
    panel_type_out <= t;
    line_out <= l;
    pixel_out <= p;
  endtask
endmodule

//--- tb/tb_paz_area_zero.sv
`timescale 1ns/1ps
`include "paz_params.svh"
module tb_paz_area_zero
  import paz_pkg::*;
;
  logic clk_in;
  logic sys_rst_in;
  logic rd, wr, wq, act, en, blk;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdata, bnd, q;
  logic [2:0] typ;
  logic [8:0] ln, px;
  int failures;
  int n_tests;
  paz_area_zero paz_area_zero_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
    .panel_type_in(typ), .line_in(ln), .pixel_in(px), .area_active_out(act),
    .partial_en_out(en), .block_type_out(blk), .bounds_out(bnd));
  paz_panel_model paz_panel_model_i (.clk_in(clk_in), .panel_type_out(typ),
    .line_out(ln), .pixel_out(px));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------
  // Checking and bus tasks
  // ----------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One Avalon access; held until waitrequest is sampled low at a rising edge
  task automatic acc_be(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] b);
    int n;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      failures++;
      end_sim;
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    acc_be(w, a, d, 4'hF);
  endtask
  task automatic ar(input logic [2:0] t, input logic [8:0] l, input logic [8:0] p, input logic e);
    paz_panel_model_i.place(t, l, p);
    repeat (2) @(negedge clk_in);
    chk("area_active", {31'h0, act}, {31'h0, e});
  endtask
  // ----------------------------
  // Main sequence
  // ----------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    sys_rst_in = 1'b1;
    {rd, wr, adr, wd, be} = '0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("bounds reset", q, `PAZ_BOUNDS_RST);
    acc(1'b1, `PAZ_OFF_BOUNDS, 32'hFFFFFFFF);
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("unused bits", q, 32'h3F3F3F3F);
    acc(1'b1, `PAZ_OFF_BOUNDS, 32'h02030101);
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("bounds read", q, 32'h02030101);
    chk("bounds_out", bnd, 32'h02030101);
    acc(1'b0, 8'h00, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("Test registers done");
    acc(1'b1, `PAZ_OFF_CTRL, 32'hFFFFFFFF);
    acc(1'b0, `PAZ_OFF_CTRL, 32'h0);
    chk("ctrl read", q, 32'h00000018);
    chk("ctrl outs", {30'h0, en, blk}, 32'h3);
    ar(3'h3, 9'h008, 9'h008, 1'b1);
    ar(3'h3, 9'h017, 9'h008, 1'b1);
    ar(3'h3, 9'h008, 9'h01F, 1'b1);
    ar(3'h3, 9'h018, 9'h008, 1'b0);
    ar(3'h3, 9'h008, 9'h020, 1'b0);
    ar(3'h3, 9'h007, 9'h008, 1'b0);
    ar(3'h3, 9'h008, 9'h007, 1'b0);
    ar(3'h2, 9'h008, 9'h008, 1'b0);
    $display("Test block area done");
    acc(1'b1, `PAZ_OFF_CTRL, 32'h00000010);
    ar(3'h3, 9'h008, 9'h064, 1'b1);
    ar(3'h3, 9'h01E, 9'h064, 1'b0);
    acc(1'b1, `PAZ_OFF_CTRL, 32'h00000000);
    ar(3'h3, 9'h008, 9'h008, 1'b0);
    $display("Test stripe and enable done");
    acc(1'b1, 8'h00, 32'hFFFFFFFF);
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("unmapped write", q, 32'h02030101);
    acc_be(1'b1, `PAZ_OFF_BOUNDS, 32'hFFFF05FF, 4'h2);
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("lane write", q, 32'h02030501);
    $display("Test byte lanes done");
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    acc(1'b0, `PAZ_OFF_BOUNDS, 32'h0);
    chk("bounds after reset", q, `PAZ_BOUNDS_RST);
    chk("enable after reset", {31'h0, en}, 32'h0);
    $display("Test mid reset done");
    end_sim;
  end
endmodule
